// ### rtl/pwm_tb_pkg.sv
/*
  Shared constants for the PWM time base control and unlock block.
  Assumes a single peripheral clock and an APB register slave.
*/
package pwm_tb_pkg;
  // Register byte addresses
  localparam logic [7:0]  ADDR_TIME_BASE_CTRL = 8'h00;
  localparam logic [7:0]  ADDR_PERIOD         = 8'h04;
  localparam logic [7:0]  ADDR_EVENT_CMP      = 8'h08;
  localparam logic [7:0]  ADDR_UNLOCK_KEY     = 8'h0c;
  localparam logic [7:0]  ADDR_OUT_CTRL_BASE  = 8'h10;
  localparam logic [7:0]  ADDR_FAULT_BASE     = 8'h30;
  localparam logic [7:0]  ADDR_STATUS         = 8'h50;
  // Time base control fields
  localparam int          BIT_MODULE_ON       = 15;
  localparam int          BIT_UNUSED          = 14;
  localparam int          BIT_IDLE_HALT       = 13;
  localparam int          BIT_EVENT_PENDING   = 12;
  localparam int          BIT_EVENT_IRQ_ON    = 11;
  localparam int          BIT_IMMEDIATE_UPD   = 10;
  localparam int          BIT_SYNC_INVERT     = 9;
  localparam int          BIT_SYNC_OUT_ON     = 8;
  localparam int          BIT_EXT_SYNC_ON     = 7;
  localparam int          SRC_LSB             = 4;
  localparam int          PS_LSB              = 0;
  localparam logic [15:0] CTRL_WMASK          = 16'hafff;
  localparam logic [2:0]  SRC_INPUT_ONE       = 3'h0;
  localparam logic [2:0]  SRC_INPUT_TWO       = 3'h1;
  // Reset values
  localparam logic [15:0] CTRL_RESET          = 16'h0000;
  localparam logic [15:0] PERIOD_RESET        = 16'hfff8;
  localparam logic [15:0] EVENT_CMP_RESET     = 16'h0000;
  localparam logic [15:0] PROT_RESET          = 16'h0000;
  // Unlock keys
  localparam logic [15:0] KEY_FIRST           = 16'habcd;
  localparam logic [15:0] KEY_SECOND          = 16'h4321;
  localparam int          NUM_GEN             = 5;
  // Unlock sequencer states
  typedef enum logic [1:0] {
    LOCK_IDLE,
    LOCK_GOT_FIRST,
    LOCK_OPEN
  } lock_state_t;
endpackage : pwm_tb_pkg

// ### rtl/pwm_unlock_seq.sv
/*
  Key sequencer granting a single protected write after the key pair.
  Assumes one bus access pulse per completed APB transfer.
*/
`timescale 1ns/10ps
module pwm_unlock_seq
  import pwm_tb_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        sys_rst_in,
  // Access events
  input  wire logic        access_in,
  input  wire logic        key_write_in,
  input  wire logic [15:0] wdata_in,
  // Grant
  output logic             open_out
);
  typedef struct packed {
    lock_state_t st;
  } seq_t;
  seq_t state_reg;
  seq_t state_next;

  // Any access not continuing the sequence drops back to locked
  always_comb begin
    state_next = state_reg;
    if (access_in) begin
      state_next.st = LOCK_IDLE;                                    // [RQ4] [RQ5]
      case (state_reg.st)
        LOCK_IDLE: begin
          if (key_write_in && wdata_in == KEY_FIRST) state_next.st = LOCK_GOT_FIRST; // [RQ3]
        end
        LOCK_GOT_FIRST: begin
          if (key_write_in && wdata_in == KEY_SECOND) state_next.st = LOCK_OPEN;     // [RQ3]
          else if (key_write_in && wdata_in == KEY_FIRST) state_next.st = LOCK_GOT_FIRST;
        end
        LOCK_OPEN: begin
          if (key_write_in && wdata_in == KEY_FIRST) state_next.st = LOCK_GOT_FIRST;
        end
        default: state_next.st = LOCK_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) state_reg <= '{st: LOCK_IDLE};
    else            state_reg <= state_next;
  end

  assign open_out = (state_reg.st == LOCK_OPEN);
endmodule : pwm_unlock_seq

// ### rtl/pwm_postscaler.sv
/*
  Special event postscaler: one trigger per (code+1) compare matches.
  Assumes match pulses are one cycle wide.
*/
`timescale 1ns/10ps
module pwm_postscaler
  import pwm_tb_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk_in,
  input  wire logic       sys_rst_in,
  // Control
  input  wire logic       run_in,
  input  wire logic [3:0] ratio_in,
  input  wire logic       match_in,
  // Trigger
  output logic            trig_out
);
  typedef struct packed {
    logic [3:0] cnt;
    logic       trig;
  } ps_t;
  ps_t state_reg;
  ps_t state_next;

  // Count matches; wrap and fire when the count reaches the code
  always_comb begin
    state_next      = state_reg;
    state_next.trig = 1'b0;
    if (!run_in) begin
      state_next.cnt = 4'h0;                                        // [RQ21]
    end else if (match_in) begin
      if (state_reg.cnt >= ratio_in) begin                          // [RQ15] [RQ16]
        state_next.cnt  = 4'h0;
        state_next.trig = 1'b1;
      end else begin
        state_next.cnt = state_reg.cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) state_reg <= '{cnt: 4'h0, trig: 1'b0};
    else            state_reg <= state_next;
  end

  assign trig_out = state_reg.trig;
endmodule : pwm_postscaler

// ### rtl/pwm_time_base_control_unlock.sv
/*
  Primary time base control with key-guarded protected registers, APB slave.
  Assumes APB master with 32-bit data; sync inputs synchronous to the clock.
*/
// The implementer's own choices: the placing of the registers and the APB register port.
// How it works
// (RQ1) Protected registers ignore writes while locked
// (RQ2) Lock config bit 1 protects, 0 disables
// (RQ3) Unlock needs 0xABCD then 0x4321 keys
// (RQ4) Protected write must be the next access
// (RQ5) One unlock grants exactly one protected write
// (RQ6) Bit 15 enables the PWM module
// (RQ7) Bit 13 halts time base in idle
// (RQ8) Bit 12 reads pending special event
// (RQ9) Bit 11 gates the special event interrupt
// (RQ10) Bit 10 loads period immediately, else boundary
// (RQ11) Bit 9 inverts sync input and output
// (RQ12) Bit 8 enables the sync output
// (RQ13) Bit 7 syncs time base to input
// (RQ14) Bits 6-4 select sync input one/two
// (RQ15) Bits 3-0 set matches per trigger
// (RQ16) Code n triggers every n+1 matches
// (RQ17) Software changes settings only while disabled
// (RQ18) Software sets period above external sync period
// (RQ19) Bit 14 reads zero, ignores writes
// (RQ20) Five generators, ten high/low outputs
// (RQ21) Disabled module holds counter at zero
`timescale 1ns/10ps
module pwm_time_base_control_unlock
  import pwm_tb_pkg::*;
#(
  parameter int GEN_COUNT = NUM_GEN
) (
  // Clock and reset
  input  wire logic                   core_clk_in,
  input  wire logic                   sys_rst_in,
  // APB slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // Device options and CPU state
  input  wire logic                   write_protect_config,
  input  wire logic                   cpu_idle_in,
  // External sync
  input  wire logic                   sync_input_one,
  input  wire logic                   sync_input_two,
  output logic                        primary_sync_output,
  // Events and outputs
  output logic                        special_event_irq_out,
  output logic                        special_event_trig_out,
  output logic                        module_on_out,
  output logic [2*GEN_COUNT-1:0]      pwm_pins_out,
  output logic [GEN_COUNT*16-1:0]     output_control_regs,
  output logic [GEN_COUNT*16-1:0]     fault_limit_control_regs
);
  typedef struct packed {
    logic [15:0]                ctrl;
    logic [15:0]                period_buf;
    logic [15:0]                period_act;
    logic                       period_dirty;
    logic [15:0]                event_cmp;
    logic [15:0]                counter;
    logic                       sync_prev;
    logic                       sync_out;
    logic [31:0]                rdata;
    logic [GEN_COUNT-1:0][15:0] ioc;
    logic [GEN_COUNT-1:0][15:0] flt;
    logic [2*GEN_COUNT-1:0]     pins;
  } tb_t;
  tb_t state_reg;
  tb_t state_next;

  logic        access;
  logic        wr;
  logic        key_write;
  logic        unlocked;
  logic        sync_sel;
  logic        sync_level;
  logic        sync_edge;
  logic        running;
  logic        wrap;
  logic        match;
  logic        trig;
  logic        prot_ok;
  logic [15:0] wdata16;

  // Completed APB transfer; zero-wait slave
  assign access    = psel && penable;
  assign wr        = access && pwrite;
  assign wdata16   = pwdata[15:0];
  assign key_write = wr && (paddr == ADDR_UNLOCK_KEY);
  assign prot_ok   = !write_protect_config || unlocked;              // [RQ1] [RQ2]

  pwm_unlock_seq u_unlock (
    .core_clk_in  (core_clk_in),
    .sys_rst_in   (sys_rst_in),
    .access_in    (access),
    .key_write_in (key_write),
    .wdata_in     (wdata16),
    .open_out     (unlocked)
  );

  // Sync source select and polarity
  always_comb begin
    case (state_reg.ctrl[SRC_LSB+:3])
      SRC_INPUT_ONE: sync_sel = sync_input_one;                     // [RQ14]
      SRC_INPUT_TWO: sync_sel = sync_input_two;                     // [RQ14]
      default:       sync_sel = 1'b0;
    endcase
  end
  assign sync_level = sync_sel ^ state_reg.ctrl[BIT_SYNC_INVERT];   // [RQ11]
  assign sync_edge  = sync_level && !state_reg.sync_prev && state_reg.ctrl[BIT_EXT_SYNC_ON]; // [RQ13]

  // Time base runs when enabled, unless halted in idle
  assign running = state_reg.ctrl[BIT_MODULE_ON] &&
                   !(cpu_idle_in && state_reg.ctrl[BIT_IDLE_HALT]); // [RQ6] [RQ7]
  assign wrap    = running && (state_reg.counter >= state_reg.period_act);
  assign match   = running && (state_reg.counter == state_reg.event_cmp);

  pwm_postscaler u_post (
    .core_clk_in (core_clk_in),
    .sys_rst_in  (sys_rst_in),
    .run_in      (state_reg.ctrl[BIT_MODULE_ON]),
    .ratio_in    (state_reg.ctrl[PS_LSB+:4]),
    .match_in    (match),
    .trig_out    (trig)
  );

  // Next-state logic for registers, counter and outputs
  always_comb begin
    state_next           = state_reg;
    state_next.sync_prev = sync_level;
    state_next.sync_out  = 1'b0;
    state_next.rdata     = 32'h0000_0000;
    // Pending flag: trigger set wins over any clear
    if (trig && state_reg.ctrl[BIT_EVENT_IRQ_ON])
      state_next.ctrl[BIT_EVENT_PENDING] = 1'b1;                     // [RQ8] [RQ9]
    // Register writes
    if (wr) begin
      case (paddr)
        ADDR_TIME_BASE_CTRL: begin
          state_next.ctrl = (wdata16 & CTRL_WMASK) |
                            (state_reg.ctrl & ~CTRL_WMASK);          // [RQ19]
          // Writing the pending bit as zero acknowledges the event
          if (!wdata16[BIT_EVENT_PENDING] && !(trig && state_reg.ctrl[BIT_EVENT_IRQ_ON]))
            state_next.ctrl[BIT_EVENT_PENDING] = 1'b0;
          else if (trig && state_reg.ctrl[BIT_EVENT_IRQ_ON])
            state_next.ctrl[BIT_EVENT_PENDING] = 1'b1;
        end
        ADDR_PERIOD: begin
          state_next.period_buf = wdata16;
          if (state_reg.ctrl[BIT_IMMEDIATE_UPD])
            state_next.period_act = wdata16;                         // [RQ10]
          else
            state_next.period_dirty = 1'b1;                          // [RQ10]
        end
        ADDR_EVENT_CMP: state_next.event_cmp = wdata16;
        default: ;
      endcase
      for (int g = 0; g < GEN_COUNT; g++) begin
        if (prot_ok && paddr == ADDR_OUT_CTRL_BASE + 8'(4 * g))
          state_next.ioc[g] = wdata16;                               // [RQ1] [RQ5]
        if (prot_ok && paddr == ADDR_FAULT_BASE + 8'(4 * g))
          state_next.flt[g] = wdata16;                               // [RQ1] [RQ5]
      end
    end
    // Register reads
    if (psel && !pwrite) begin
      case (paddr)
        ADDR_TIME_BASE_CTRL: state_next.rdata = {16'h0000, state_reg.ctrl};
        ADDR_PERIOD:         state_next.rdata = {16'h0000, state_reg.period_buf};
        ADDR_EVENT_CMP:      state_next.rdata = {16'h0000, state_reg.event_cmp};
        ADDR_STATUS:         state_next.rdata = {15'h0000, unlocked, state_reg.counter};
        default:             state_next.rdata = 32'h0000_0000;
      endcase
      for (int g = 0; g < GEN_COUNT; g++) begin
        if (paddr == ADDR_OUT_CTRL_BASE + 8'(4 * g))
          state_next.rdata = {16'h0000, state_reg.ioc[g]};
        if (paddr == ADDR_FAULT_BASE + 8'(4 * g))
          state_next.rdata = {16'h0000, state_reg.flt[g]};
      end
    end
    // Time base counter
    if (!state_reg.ctrl[BIT_MODULE_ON]) begin
      state_next.counter = 16'h0000;                                 // [RQ21]
    end else if (sync_edge || wrap) begin
      state_next.counter = 16'h0000;                                 // [RQ13]
      state_next.sync_out = 1'b1;
      if (state_reg.period_dirty && !(wr && paddr == ADDR_PERIOD)) begin
        state_next.period_act   = state_reg.period_buf;              // [RQ10]
        state_next.period_dirty = 1'b0;
      end
    end else if (running) begin
      state_next.counter = state_reg.counter + 16'h0001;
    end
    // Simple edge-aligned outputs: high half, low complement while running, both low when stopped
    for (int g = 0; g < GEN_COUNT; g++) begin
      state_next.pins[2*g]   = running && (state_reg.counter < (state_reg.period_act >> 1));
      state_next.pins[2*g+1] = running && !(state_reg.counter < (state_reg.period_act >> 1)); // [RQ20]
    end
  end

  // Single register stage for all state
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      state_reg <= '{ctrl: CTRL_RESET, period_buf: PERIOD_RESET, period_act: PERIOD_RESET,
                     period_dirty: 1'b0, event_cmp: EVENT_CMP_RESET, counter: 16'h0000,
                     sync_prev: 1'b0, sync_out: 1'b0, rdata: 32'h0000_0000,
                     ioc: '0, flt: '0, pins: '0};
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs
  assign prdata                 = state_reg.rdata;
  assign pready                 = 1'b1;
  assign pslverr                = 1'b0;
  assign module_on_out          = state_reg.ctrl[BIT_MODULE_ON];
  assign special_event_irq_out  = state_reg.ctrl[BIT_EVENT_PENDING]; // [RQ8]
  assign special_event_trig_out = trig;
  assign pwm_pins_out           = state_reg.pins;
  assign output_control_regs    = state_reg.ioc;
  assign fault_limit_control_regs = state_reg.flt;
  // Sync out gated by enable, pulse polarity follows invert bit
  assign primary_sync_output = (state_reg.sync_out && state_reg.ctrl[BIT_SYNC_OUT_ON]) ^
                               state_reg.ctrl[BIT_SYNC_INVERT];      // [RQ11] [RQ12]
endmodule : pwm_time_base_control_unlock

// ### test/pwm_tbcu_props.sv
/* Port assertions for the PWM time base control block.
   Assumes a bind onto the top module and one clock domain. */
`timescale 1ns/10ps
module pwm_tbcu_props
  import pwm_tb_pkg::*;
#(
  parameter int GEN_COUNT = NUM_GEN
) (
  // Clock, reset and bus
  input wire logic                    core_clk_in,
  input wire logic                    sys_rst_in,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [7:0]              paddr,
  input wire logic [31:0]             prdata,
  // Observed outputs
  input wire logic                    module_on_out,
  input wire logic                    special_event_trig_out,
  input wire logic                    special_event_irq_out,
  input wire logic [GEN_COUNT*16-1:0] output_control_regs,
  input wire logic [GEN_COUNT*16-1:0] fault_limit_control_regs
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  // Completed write; protected registers, the enable and a pending clear may only move behind one
  wire wr_acc = psel && penable && pwrite;
  property p_key_rd;
    psel && penable && !pwrite && paddr == ADDR_UNLOCK_KEY |-> prdata == 32'h0; endproperty
  a_key_rd: assert property (p_key_rd) else $error("key read not zero");
  property p_oc_chg;
    $changed(output_control_regs) |-> $past(wr_acc); endproperty
  a_oc_chg: assert property (p_oc_chg) else $error("output control moved");
  property p_flt_chg;
    $changed(fault_limit_control_regs) |-> $past(wr_acc); endproperty
  a_flt_chg: assert property (p_flt_chg) else $error("fault control moved");
  property p_on_chg;
    $changed(module_on_out) |-> $past(wr_acc); endproperty
  a_on_chg: assert property (p_on_chg) else $error("enable moved");
  property p_trig_off;
    !module_on_out && !$past(module_on_out) |-> !special_event_trig_out; endproperty
  a_trig_off: assert property (p_trig_off) else $error("trigger while off");
  property p_trig_one;
    special_event_trig_out |=> !special_event_trig_out; endproperty
  a_trig_one: assert property (p_trig_one) else $error("trigger too long");
  property p_irq_rise;
    $rose(special_event_irq_out) |-> special_event_trig_out ||
      $past(special_event_trig_out) || $past(special_event_trig_out, 2); endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq without trigger");
  property p_irq_fall;
    $fell(special_event_irq_out) |-> $past(wr_acc); endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped alone");
  // Main scenarios reached
  c_trig: cover property (special_event_trig_out);
  c_irq: cover property ($rose(special_event_irq_out));
  c_oc: cover property ($changed(output_control_regs));
endmodule : pwm_tbcu_props
bind pwm_time_base_control_unlock pwm_tbcu_props #(.GEN_COUNT(GEN_COUNT)) u_props (.*);

// ### test/pwm_time_base_control_unlock_tb_top.sv
/* Self-checking bench for the PWM time base control block over APB.
   Assumes the package register map and a 20 MHz clock. */
`timescale 1ns/10ps
module pwm_time_base_control_unlock_tb_top
  import pwm_tb_pkg::*;
;
  logic        core_clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, primary_sync_output, module_on_out;
  logic        special_event_irq_out, special_event_trig_out;
  logic        write_protect_config = 1'b1, cpu_idle_in = 1'b0;
  logic        sync_input_one = 1'b0, sync_input_two = 1'b0;
  logic [9:0]  pwm_pins_out;
  logic [79:0] output_control_regs, fault_limit_control_regs;
  logic [15:0] r;
  int          fails = 0, n_compared = 0, cyc = 0, t, tp, c;
  int          ps[3] = '{0, 1, 15};
  pwm_time_base_control_unlock dut (.*);
  // Clock and a hang guard sized well past the longest scenario
  always #25 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == 30000) begin
      fails++;
      tally_and_finish();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      fails++;
    end
  endtask : chk
  // One APB transfer; idles a cycle first so strobes never toggle twice per step
  task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge core_clk_in);
    penable <= 1'b1;
    // Wait on pready itself; only the bench timeout ends a hang
    do begin
      @(posedge core_clk_in);
    end while (pready !== 1'b1);
    r = prdata[15:0];
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Register outputs update on the write edge, so compare only once settled
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    apb(1'b1, a, d);
    @(negedge core_clk_in);
  endtask : wr
  task automatic rd(input string nm, input logic [7:0] a, input logic [15:0] e);
    apb(1'b0, a, 16'h0000);
    chk(nm, {16'h0000, e}, {16'h0000, r});
  endtask : rd
  // Cycles between two pulses of trigger (tr=1) or sync output
  task automatic span(input bit tr, output int n);
    int k;
    n = 0;
    for (k = 0; k < 4000; k++) begin
      @(posedge core_clk_in);
      if ((tr ? special_event_trig_out : primary_sync_output) === 1'b1) break;
    end
    for (k = 0; k < 4000; k++) begin
      @(posedge core_clk_in);
      n++;
      if ((tr ? special_event_trig_out : primary_sync_output) === 1'b1) break;
    end
  endtask : span
  task automatic cnt(input int w);
    c = 0;
    repeat (w) begin
      @(posedge core_clk_in);
      if (primary_sync_output === 1'b1) c++;
    end
  endtask : cnt
  task automatic unl();
    wr(ADDR_UNLOCK_KEY, KEY_FIRST);
    wr(ADDR_UNLOCK_KEY, KEY_SECOND);
  endtask : unl
  // External sync edge on input two while the period is far away
  task automatic xs(input logic [15:0] ctl);
    wr(ADDR_TIME_BASE_CTRL, ctl);
    repeat (5) @(posedge core_clk_in);
    sync_input_two <= 1'b1;
    cnt(12);
    sync_input_two <= 1'b0;
  endtask : xs
  task automatic tally_and_finish();
    $display("fails %0d n_compared %0d", fails, n_compared);
    if (fails == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  // Main sequence
  initial begin
    repeat (8) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    rd("ctrl reset", ADDR_TIME_BASE_CTRL, CTRL_RESET);
    rd("period reset", ADDR_PERIOD, PERIOD_RESET);
    rd("key read", ADDR_UNLOCK_KEY, 16'h0000);
    rd("unmapped", 8'hfc, 16'h0000);
    chk("pin count", 32'd10, $bits(pwm_pins_out));
    wr(ADDR_TIME_BASE_CTRL, 16'h7fff);
    rd("ctrl fixed bits", ADDR_TIME_BASE_CTRL, 16'h2fff);
    wr(ADDR_TIME_BASE_CTRL, 16'h0400);
    wr(ADDR_PERIOD, 16'h0010);
    wr(ADDR_EVENT_CMP, 16'h0008);
    wr(ADDR_TIME_BASE_CTRL, 16'h8100);
    span(1'b0, tp);
    wr(ADDR_PERIOD, 16'h0020);
    span(1'b0, t);
    span(1'b0, t);
    chk("deferred period", tp + 16, t);
    tp = t;
    foreach (ps[i]) begin
      c = ps[i];
      wr(ADDR_TIME_BASE_CTRL, 16'h0100 | c[15:0]);
      wr(ADDR_TIME_BASE_CTRL, 16'h8100 | c[15:0]);
      span(1'b1, t);
      chk("postscale", (c + 1) * tp, t);
    end
    rd("no pending", ADDR_TIME_BASE_CTRL, 16'h810f);
    wr(ADDR_TIME_BASE_CTRL, 16'h8800);
    span(1'b1, t);
    rd("pending", ADDR_TIME_BASE_CTRL, 16'h9800);
    chk("irq high", 1, special_event_irq_out);
    wr(ADDR_TIME_BASE_CTRL, 16'h0000);
    rd("cleared", ADDR_TIME_BASE_CTRL, 16'h0000);
    chk("irq low", 0, special_event_irq_out);
    cnt(100);
    chk("off pulses", 0, c);
    cpu_idle_in <= 1'b1;
    wr(ADDR_TIME_BASE_CTRL, 16'ha100);
    cnt(100);
    chk("idle halt", 0, c);
    wr(ADDR_TIME_BASE_CTRL, 16'h8100);
    cnt(100);
    chk("idle run", 1, c > 0);
    cpu_idle_in <= 1'b0;
    wr(ADDR_TIME_BASE_CTRL, 16'h0300);
    cnt(2);
    chk("sync idle high", 1, primary_sync_output);
    wr(ADDR_TIME_BASE_CTRL, 16'h0400);
    wr(ADDR_PERIOD, 16'hfff8);
    xs(16'h8190);
    chk("sync two", 1, c);
    xs(16'h8180);
    chk("sync one", 0, c);
    xs(16'h8110);
    chk("sync off", 0, c);
    wr(ADDR_OUT_CTRL_BASE, 16'h1234);
    chk("locked", 0, output_control_regs[15:0]);
    unl();
    wr(ADDR_OUT_CTRL_BASE, 16'h1234);
    chk("unlocked", 16'h1234, output_control_regs[15:0]);
    wr(ADDR_OUT_CTRL_BASE, 16'h5555);
    chk("one write", 16'h1234, output_control_regs[15:0]);
    wr(ADDR_UNLOCK_KEY, KEY_SECOND);
    wr(ADDR_UNLOCK_KEY, KEY_FIRST);
    wr(ADDR_FAULT_BASE + 8'h04, 16'h1111);
    chk("key order", 0, fault_limit_control_regs[31:16]);
    unl();
    rd("between", ADDR_TIME_BASE_CTRL, 16'h8110);
    wr(ADDR_FAULT_BASE + 8'h04, 16'h1111);
    chk("access between", 0, fault_limit_control_regs[31:16]);
    unl();
    wr(ADDR_FAULT_BASE + 8'h04, 16'h2222);
    chk("fault write", 16'h2222, fault_limit_control_regs[31:16]);
    @(posedge core_clk_in);
    write_protect_config <= 1'b0;
    wr(ADDR_OUT_CTRL_BASE + 8'h10, 16'h7777);
    chk("no protect", 16'h7777, output_control_regs[79:64]);
    tally_and_finish();
  end
endmodule : pwm_time_base_control_unlock_tb_top
